// ==== rtl/comparator_window_control.sv ====
// Digital control around one analog comparator: registers, output shaping,
// window pairing, match flag and sleep handling.
// Assumes the analog core and partner results arrive asynchronously and the
// sleep code comes from the power manager on clk_i.
//
// The Wishbone interface to the registers was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module comparator_window_control (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [4:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  input  wire logic                                cmp_raw_i,
  input  wire logic                                partner_raw_i,
  input  wire logic [1:0]                          sleep_mode_i,
  output comparator_window_pkg::analog_ctrl_s      analog_ctrl_o,
  output logic                                     out_pin_o,
  output logic                                     out_pin_oe_o,
  output logic                                     level_event_o,
  output logic                                     irq_o
);

  // ===========================================================================
  // Declarations
  logic [7:0]  control_a_reg;
  logic [7:0]  control_b_reg;
  logic [7:0]  input_selection_reg;
  logic [7:0]  threshold_level_code_reg;
  logic [7:0]  irq_control_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [7:0]  read_next;
  logic [2:0]  reg_idx;
  logic        wr_fire;
  logic        cmp_meta_reg;
  logic        cmp_sync_reg;
  logic        part_meta_reg;
  logic        part_sync_reg;
  logic        out_prev_reg;
  logic        match_prev_reg;
  logic [1:0]  range_reg;
  logic        match_level_reg;
  logic        match_flag_reg;
  logic        flag_set;
  logic        flag_clear;
  logic        status_hold;
  logic        core_on;
  logic        window_on;
  logic        out_sync;
  logic        out_async;
  logic [1:0]  range_next;
  logic        match_next;
  logic [5:0]  start_cnt_reg;
  logic [1:0]  trig;

  comparator_window_pkg::core_state_e state_reg;
  comparator_window_pkg::core_state_e state_next;

  // ===========================================================================
  // Wishbone slave: one wait state, answer in the cycle after the request
  assign reg_idx = wb_adr_i[4:2];
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Ack falls after one cycle; a request held past the ack is answered again two cycles later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Read data; unmapped and reserved offsets read zero
  always_comb begin
    read_next = 8'h00;
    if (reg_idx == comparator_window_pkg::IDX_CONTROL_A) begin
      read_next = control_a_reg;
    end else if (reg_idx == comparator_window_pkg::IDX_CONTROL_B) begin
      read_next = control_b_reg;
    end else if (reg_idx == comparator_window_pkg::IDX_INPUT_SELECTION) begin
      read_next = input_selection_reg;
    end else if (reg_idx == comparator_window_pkg::IDX_THRESHOLD) begin
      read_next = threshold_level_code_reg;
    end else if (reg_idx == comparator_window_pkg::IDX_IRQ_CONTROL) begin
      read_next = irq_control_reg;
    end else if (reg_idx == comparator_window_pkg::IDX_STATUS) begin
      read_next = {range_reg, 1'b0, match_level_reg, 3'h0, match_flag_reg};
    end
  end

  // Capture read data while waiting so it is stable at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      dat_reg <= {24'h00_0000, read_next};
    end else begin
      dat_reg <= 32'h0000_0000;
    end
  end

  // ===========================================================================
  // Configuration registers, written at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_a_reg <= comparator_window_pkg::CONTROL_A_RESET;
    end else if (wr_fire && reg_idx == comparator_window_pkg::IDX_CONTROL_A) begin
      control_a_reg <= wb_dat_i[7:0] & comparator_window_pkg::CONTROL_A_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_b_reg <= comparator_window_pkg::CONTROL_B_RESET;
    end else if (wr_fire && reg_idx == comparator_window_pkg::IDX_CONTROL_B) begin
      control_b_reg <= wb_dat_i[7:0] & comparator_window_pkg::CONTROL_B_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_selection_reg <= comparator_window_pkg::INPUT_SEL_RESET;
    end else if (wr_fire && reg_idx == comparator_window_pkg::IDX_INPUT_SELECTION) begin
      input_selection_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_level_code_reg <= comparator_window_pkg::THRESHOLD_RESET;
    end else if (wr_fire && reg_idx == comparator_window_pkg::IDX_THRESHOLD) begin
      threshold_level_code_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_control_reg <= comparator_window_pkg::IRQ_CONTROL_RESET;
    end else if (wr_fire && reg_idx == comparator_window_pkg::IDX_IRQ_CONTROL) begin
      irq_control_reg <= wb_dat_i[7:0] & comparator_window_pkg::IRQ_CONTROL_MASK;
    end
  end

  // ===========================================================================
  // Sleep handling and settings to the analog core
  // Idle is treated like active; only standby and power-down change anything
  assign core_on = control_a_reg[comparator_window_pkg::CA_ENABLE_BIT]
                 && (sleep_mode_i != comparator_window_pkg::SLEEP_POWERDOWN)
                 && !(sleep_mode_i == comparator_window_pkg::SLEEP_STANDBY
                      && !control_a_reg[comparator_window_pkg::CA_KEEP_RUN_BIT]);
  assign status_hold = (sleep_mode_i == comparator_window_pkg::SLEEP_STANDBY);

  always_comb begin
    analog_ctrl_o.core_on              = core_on;
    analog_ctrl_o.power_profile        = control_a_reg[comparator_window_pkg::CA_POWER_LSB +: 2];
    analog_ctrl_o.hysteresis_select    = control_a_reg[comparator_window_pkg::CA_HYST_LSB +: 2];
    analog_ctrl_o.plus_input_sel       = input_selection_reg[comparator_window_pkg::IS_PLUS_LSB +: 3];
    analog_ctrl_o.minus_input_sel      = input_selection_reg[comparator_window_pkg::IS_MINUS_LSB +: 3];
    analog_ctrl_o.threshold_level_code = threshold_level_code_reg;
  end

  // ===========================================================================
  // Start-up sequence of the analog core
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      comparator_window_pkg::CORE_OFF: begin
        if (core_on) begin
          state_next = comparator_window_pkg::CORE_STARTING;
        end
      end
      comparator_window_pkg::CORE_STARTING: begin
        if (!core_on) begin
          state_next = comparator_window_pkg::CORE_OFF;
        end else if (start_cnt_reg == 6'(comparator_window_pkg::STARTUP_CYCLES - 1)) begin
          state_next = comparator_window_pkg::CORE_READY;
        end
      end
      comparator_window_pkg::CORE_READY: begin
        if (!core_on) begin
          state_next = comparator_window_pkg::CORE_OFF;
        end
      end
      default: begin
        state_next = comparator_window_pkg::CORE_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= comparator_window_pkg::CORE_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counts start-up cycles; cleared whenever the core is not starting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_cnt_reg <= 6'h00;
    end else if (state_reg == comparator_window_pkg::CORE_STARTING) begin
      start_cnt_reg <= start_cnt_reg + 6'h01;
    end else begin
      start_cnt_reg <= 6'h00;
    end
  end

  // ===========================================================================
  // Output shaping
  // The pin and event path stays combinational so it works with the clock stopped
  always_comb begin
    if (state_reg != comparator_window_pkg::CORE_READY) begin
      out_async = input_selection_reg[comparator_window_pkg::IS_STARTUP_BIT];
    end else begin
      out_async = cmp_raw_i ^ input_selection_reg[comparator_window_pkg::IS_INVERT_BIT];
    end
  end

  assign out_pin_o     = out_async;
  assign level_event_o = out_async;
  assign out_pin_oe_o  = control_a_reg[comparator_window_pkg::CA_PIN_DRIVE_BIT]
                       && (sleep_mode_i != comparator_window_pkg::SLEEP_POWERDOWN);

  // ===========================================================================
  // Synchronisers for the asynchronous comparator results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta_reg  <= 1'b0;
      cmp_sync_reg  <= 1'b0;
      part_meta_reg <= 1'b0;
      part_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg  <= cmp_raw_i;
      cmp_sync_reg  <= cmp_meta_reg;
      part_meta_reg <= partner_raw_i;
      part_sync_reg <= part_meta_reg;
    end
  end

  // ===========================================================================
  // Window and match evaluation
  assign window_on = (control_b_reg[1:0] == comparator_window_pkg::PARTNER_NEXT);
  assign trig      = irq_control_reg[comparator_window_pkg::IC_TRIGGER_LSB +: 2];

  always_comb begin
    if (state_reg != comparator_window_pkg::CORE_READY) begin
      out_sync = input_selection_reg[comparator_window_pkg::IS_STARTUP_BIT];
    end else begin
      out_sync = cmp_sync_reg ^ input_selection_reg[comparator_window_pkg::IS_INVERT_BIT];
    end
  end

  // This comparator holds the upper limit, the partner the lower one
  always_comb begin
    if (cmp_sync_reg) begin
      range_next = comparator_window_pkg::RANGE_ABOVE;
    end else if (!part_sync_reg) begin
      range_next = comparator_window_pkg::RANGE_BELOW;
    end else begin
      range_next = comparator_window_pkg::RANGE_INSIDE;
    end
  end

  always_comb begin
    if (!window_on) begin
      match_next = out_sync;
    end else begin
      case (trig)
        comparator_window_pkg::WTRIG_ABOVE: begin
          match_next = (range_next == comparator_window_pkg::RANGE_ABOVE);
        end
        comparator_window_pkg::WTRIG_INSIDE: begin
          match_next = (range_next == comparator_window_pkg::RANGE_INSIDE);
        end
        comparator_window_pkg::WTRIG_BELOW: begin
          match_next = (range_next == comparator_window_pkg::RANGE_BELOW);
        end
        default: begin
          match_next = (range_next != comparator_window_pkg::RANGE_INSIDE);
        end
      endcase
    end
  end

  // Status snapshot; frozen in standby as if the clock had stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_reg       <= comparator_window_pkg::RANGE_ABOVE;
      match_level_reg <= 1'b0;
      out_prev_reg    <= 1'b0;
      match_prev_reg  <= 1'b0;
    end else if (!status_hold) begin
      range_reg       <= range_next;
      match_level_reg <= match_next;
      out_prev_reg    <= out_sync;
      match_prev_reg  <= match_next;
    end
  end

  // ===========================================================================
  // Match flag and interrupt
  // Window mode flags on entering a matching state, single mode on edges
  always_comb begin
    flag_set = 1'b0;
    if (state_reg == comparator_window_pkg::CORE_READY && !status_hold) begin
      if (window_on) begin
        flag_set = match_next && !match_prev_reg;
      end else begin
        case (trig)
          comparator_window_pkg::TRIG_ANY_CROSSING: begin
            flag_set = (out_sync != out_prev_reg);
          end
          comparator_window_pkg::TRIG_FALLING: begin
            flag_set = !out_sync && out_prev_reg;
          end
          comparator_window_pkg::TRIG_RISING: begin
            flag_set = out_sync && !out_prev_reg;
          end
          default: begin
            flag_set = 1'b0;
          end
        endcase
      end
    end
  end

  assign flag_clear = wr_fire && reg_idx == comparator_window_pkg::IDX_STATUS
                    && wb_dat_i[comparator_window_pkg::ST_FLAG_BIT];

  // A new event beats a clear in the same cycle so none is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_flag_reg <= 1'b0;
    end else if (flag_set) begin
      match_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      match_flag_reg <= 1'b0;
    end
  end

  assign irq_o = match_flag_reg && irq_control_reg[comparator_window_pkg::IC_IRQ_ON_BIT];

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_one_cycle;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack held longer than one cycle");

  property p_startup_level;
    (state_reg != comparator_window_pkg::CORE_READY)
      |-> (out_pin_o == input_selection_reg[comparator_window_pkg::IS_STARTUP_BIT]);
  endproperty
  a_startup_level: assert property (p_startup_level) else $error("start-up level not held");

  property p_enable_on;
    wr_fire && reg_idx == comparator_window_pkg::IDX_CONTROL_A && wb_dat_i[0]
      && sleep_mode_i == comparator_window_pkg::SLEEP_ACTIVE ##1
      sleep_mode_i == comparator_window_pkg::SLEEP_ACTIVE |-> analog_ctrl_o.core_on;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("enable write did not switch core on");

  property p_powerdown_off;
    sleep_mode_i == comparator_window_pkg::SLEEP_POWERDOWN |-> !out_pin_oe_o && !analog_ctrl_o.core_on;
  endproperty
  a_powerdown_off: assert property (p_powerdown_off) else $error("power-down left core or pin on");

  property p_inside_state;
    window_on && cmp_sync_reg == 1'b0 && part_sync_reg && !status_hold
      |=> range_reg == comparator_window_pkg::RANGE_INSIDE;
  endproperty
  a_inside_state: assert property (p_inside_state) else $error("inside window not reported");

  property p_outside_match;
    window_on && trig == comparator_window_pkg::WTRIG_OUTSIDE && !status_hold
      && range_next != comparator_window_pkg::RANGE_INSIDE |=> match_level_reg;
  endproperty
  a_outside_match: assert property (p_outside_match) else $error("outside match missing");

  property p_rise_flag;
    !window_on && trig == comparator_window_pkg::TRIG_RISING && state_reg == comparator_window_pkg::CORE_READY
      && !status_hold && out_sync && !out_prev_reg |=> match_flag_reg;
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge did not set flag");

  property p_irq_follows;
    irq_o && !wr_fire |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq dropped while flag set");

  property p_flag_clear;
    flag_clear && !flag_set |=> !match_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write one");

  property p_standby_freeze;
    status_hold |=> $stable(range_reg) && $stable(match_level_reg);
  endproperty
  a_standby_freeze: assert property (p_standby_freeze) else $error("status moved in standby");

endmodule

`default_nettype wire

// ==== rtl/comparator_window_pkg.sv ====
// Constants, register map and carrier types of the comparator window control block.
// Assumes one 40 MHz clock and a classic Wishbone slave with 32-bit data.
//
// What this block does
// - Raw result is one when plus input exceeds minus input, otherwise zero.
// - Pin output is raw result XOR the polarity flip bit.
// - While starting up, the output holds the start-up output level bit.
// - Power profile field bits 4:3: 0 fast profile, 1 low current, rest reserved.
// - Hysteresis field bits 2:1 selects none, small, medium or large.
// - Enable bit switches the comparator on or off; control A resets to zero.
// - Pin drive bit 6 of control A puts the output on the pin.
// - Pair partner field in control B selects the window partner comparator.
// - In window mode status reports above, inside or below.
// - Range position: above 0, inside 1, below 2; meaningless outside window mode.
// - In window mode the trigger field picks above, inside, below or outside.
// - Window trigger codes 0..3 mean above, inside, below, outside.
// - Match level is one when the state satisfies the selected trigger.
// - Interrupt forwarded only when the interrupt enable bit is one.
// - Asynchronous level event follows the output level; no incoming events.
// - A configured interrupt condition sets the match flag.
// - In single mode the trigger picks rising, falling or both edges.
// - Single mode codes: 0 any crossing, 2 falling, 3 rising, 1 reserved.
// - Interrupt request stays high while the match flag is set.
// - Writing one to the flag bit clears it; writing zero does nothing.
// - In idle sleep the logic runs exactly as when active.
// - In standby the comparator is off unless keep running asleep is set.
// - In standby with clock stopped, flags and interrupt state do not change.
// - In power-down the comparator and pin drive are disabled.

package comparator_window_pkg;

  // ===========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [2:0] IDX_CONTROL_A       = 3'h0;
  localparam logic [2:0] IDX_CONTROL_B       = 3'h1;
  localparam logic [2:0] IDX_INPUT_SELECTION = 3'h2;
  localparam logic [2:0] IDX_THRESHOLD       = 3'h5;
  localparam logic [2:0] IDX_IRQ_CONTROL     = 3'h6;
  localparam logic [2:0] IDX_STATUS          = 3'h7;

  // ===========================================================================
  // Field positions
  localparam int CA_ENABLE_BIT    = 0;
  localparam int CA_HYST_LSB      = 1;
  localparam int CA_POWER_LSB     = 3;
  localparam int CA_PIN_DRIVE_BIT = 6;
  localparam int CA_KEEP_RUN_BIT  = 7;
  localparam int IS_MINUS_LSB     = 0;
  localparam int IS_PLUS_LSB      = 3;
  localparam int IS_STARTUP_BIT   = 6;
  localparam int IS_INVERT_BIT    = 7;
  localparam int IC_IRQ_ON_BIT    = 0;
  localparam int IC_TRIGGER_LSB   = 4;
  localparam int ST_FLAG_BIT      = 0;

  // ===========================================================================
  // Reset values and writable masks
  localparam logic [7:0] CONTROL_A_RESET   = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET   = 8'h00;
  localparam logic [7:0] INPUT_SEL_RESET   = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET   = 8'hff;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_A_MASK    = 8'hdf;
  localparam logic [7:0] CONTROL_B_MASK    = 8'h03;
  localparam logic [7:0] IRQ_CONTROL_MASK  = 8'h31;
  localparam logic [1:0] PARTNER_NEXT      = 2'h1;

  // ===========================================================================
  // Start-up time of the analog core
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int STARTUP_NS     = 1000;
  localparam int STARTUP_CYCLES = (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ===========================================================================
  // Codes
  typedef enum logic [1:0] {
    RANGE_ABOVE  = 2'h0,
    RANGE_INSIDE = 2'h1,
    RANGE_BELOW  = 2'h2
  } range_position_e;

  typedef enum logic [1:0] {
    TRIG_ANY_CROSSING = 2'h0,
    TRIG_RESERVED     = 2'h1,
    TRIG_FALLING      = 2'h2,
    TRIG_RISING       = 2'h3
  } single_trigger_e;

  typedef enum logic [1:0] {
    WTRIG_ABOVE   = 2'h0,
    WTRIG_INSIDE  = 2'h1,
    WTRIG_BELOW   = 2'h2,
    WTRIG_OUTSIDE = 2'h3
  } window_trigger_e;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE    = 2'h0,
    SLEEP_IDLE      = 2'h1,
    SLEEP_STANDBY   = 2'h2,
    SLEEP_POWERDOWN = 2'h3
  } sleep_e;

  typedef enum logic [2:0] {
    CORE_OFF      = 3'b001,
    CORE_STARTING = 3'b010,
    CORE_READY    = 3'b100
  } core_state_e;

  // Settings carried to the analog core
  typedef struct packed {
    logic       core_on;
    logic [1:0] power_profile;
    logic [1:0] hysteresis_select;
    logic [2:0] plus_input_sel;
    logic [2:0] minus_input_sel;
    logic [7:0] threshold_level_code;
  } analog_ctrl_s;

endpackage

// ==== tb/cmp_core_model.sv ====
// Behavioural analog pair: main and partner comparator.
// Assumes the bench sets one plus level and two thresholds.
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model (
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] upper_i,
  input  wire logic [7:0] lower_i,
  output logic            raw_o,
  output logic            partner_raw_o
);
  // Shared plus pin; equal levels read low
  assign raw_o         = level_i > upper_i;
  assign partner_raw_o = level_i > lower_i;
endmodule
`default_nettype wire

// ==== tb/comparator_window_control_tb_top.sv ====
// Self-checking bench of the comparator window control block.
// Assumes the analog pair model and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module comparator_window_control_tb_top;
  logic        clk_i, rst_i, cyc, we, raw, praw;
  logic [3:0]  sel;
  logic [4:0]  adr;
  logic [31:0] wdat, wb_dat_o;
  logic [7:0]  lvl, q;
  logic [1:0]  slp;
  logic        wb_ack_o, pin, oe, evt, irq;
  comparator_window_pkg::analog_ctrl_s actl;
  int          n_errors, checks_done, ticks;
  logic [18:0] rows [7] = '{{3'h0, 8'hff, 8'hdf}, {3'h1, 8'hff, 8'h03}, {3'h2, 8'h3f, 8'h3f},
    {3'h5, 8'h5a, 8'h5a}, {3'h6, 8'hff, 8'h31}, {3'h3, 8'hff, 8'h00}, {3'h4, 8'h77, 8'h00}};
  cmp_core_model core (.level_i(lvl), .upper_i(8'h80), .lower_i(8'h20), .raw_o(raw), .partner_raw_o(praw));
  comparator_window_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_raw_i(raw), .partner_raw_i(praw), .sleep_mode_i(slp),
    .analog_ctrl_o(actl), .out_pin_o(pin), .out_pin_oe_o(oe), .level_event_o(evt), .irq_o(irq));
  // ==========
  // Bus and check tasks; calls start and end at a falling edge
  task automatic wb(input logic w, input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    // Ack and data taken at the rising edge; only the bench timeout ends a hang
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
    checks_done++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Clock and a hang guard well above the expected run
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========
  // Main sequence
  initial begin
    {cyc, we, adr, wdat, sel, slp, lvl, rst_i} = {45'h0, 8'h10, 1'b1};
    sel = 4'hf;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 3'h0, 0); chk("ctrl_a", 8'h00, q);
    wb(0, 3'h5, 0); chk("thresh", 8'hff, q);
    foreach (rows[k]) begin
      wb(1, rows[k][18:16], rows[k][15:8]);
      wb(0, rows[k][18:16], 0); chk("reg", rows[k][7:0], q);
    end
    chk("code", 8'h5a, actl.threshold_level_code);
    // Switch off first so the start-up level is seen while the core restarts
    wb(1, 3'h0, 8'h00); chk("off", 8'h0, actl.core_on);
    wb(1, 3'h2, 8'h40);
    wb(1, 3'h0, 8'h4b); chk("start", 8'h1, pin);
    chk("on", 8'h1, actl.core_on);
    chk("oe", 8'h1, oe);
    chk("prof", 8'h1, actl.power_profile);
    chk("hyst", 8'h1, actl.hysteresis_select);
    repeat (45) @(negedge clk_i);
    chk("pin", 8'h0, pin);
    wb(1, 3'h2, 8'h80); chk("inv", 8'h1, evt);
    wb(1, 3'h2, 8'h00);
    wb(1, 3'h6, 8'h31);
    wb(1, 3'h7, 8'h01);
    @(posedge clk_i) lvl <= 8'hc0;
    repeat (6) @(negedge clk_i);
    wb(1, 3'h7, 8'h00);
    wb(0, 3'h7, 0); chk("stat", 8'h11, q);
    chk("irq", 8'h1, irq);
    wb(1, 3'h7, 8'h01); chk("clr", 8'h0, irq);
    wb(1, 3'h1, 8'h01);
    wb(1, 3'h6, 8'h30);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i) lvl <= (k == 0) ? 8'hc0 : (k == 1) ? 8'h50 : 8'h10;
      repeat (6) @(negedge clk_i);
      wb(0, 3'h7, 0); chk("win", {k[1:0], 1'b0, k != 1}, q[7:4]);
    end
    for (int j = 0; j < 3; j++) begin
      wb(1, 3'h6, 8'(j << 4));
      wb(0, 3'h7, 0); chk("wtrig", 8'(j == 2), 8'(q[4]));
    end
    // Single mode, falling trigger: a rise must not flag, a fall must
    wb(1, 3'h1, 8'h00);
    wb(1, 3'h6, 8'h20);
    wb(1, 3'h7, 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) lvl <= k ? 8'h10 : 8'hc0;
      repeat (6) @(negedge clk_i);
      wb(0, 3'h7, 0); chk("fall", 8'(k), 8'(q[0]));
    end
    @(posedge clk_i) slp <= 2'h3;
    @(negedge clk_i); chk("pdown", 8'h0, oe);
    chk("pd_core", 8'h0, actl.core_on);
    @(posedge clk_i) slp <= 2'h1;
    @(negedge clk_i); chk("idle", 8'h1, oe);
    chk("idle_core", 8'h1, actl.core_on);
    // Standby without keep running: core off, status frozen at below
    @(posedge clk_i) slp <= 2'h2;
    @(negedge clk_i); chk("stby", 8'h0, actl.core_on);
    @(posedge clk_i) lvl <= 8'hc0;
    repeat (6) @(negedge clk_i);
    wb(0, 3'h7, 0); chk("frozen", 8'h8, q[7:4]);
    final_report();
  end
endmodule
`default_nettype wire
